// ===== logic/iwd_pkg.sv
// Constants and types shared by the instruction word decoder.
`default_nettype none
package iwd_pkg;
  localparam logic [3:0] MAX_WORDS = 4'h7;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_SR = 8'h08;
  localparam logic [7:0] ADR_VBR = 8'h0C;
  localparam logic [7:0] ADR_SFC = 8'h10;
  localparam logic [7:0] ADR_DFC = 8'h14;
  localparam logic [15:0] SR_RESET = 16'h2700;
  localparam logic [15:0] SR_WMASK = 16'hA71F;
  localparam int SR_S = 13;
  localparam logic [15:0] OP_NOP = 16'h4E71;
  localparam logic [15:0] OP_MOVEC = 16'h4E7A;
  localparam logic [8:0] OP_MULDIV = 9'h098;
  localparam logic [15:0] OP_LOW_POWER_STOP_INSTR = 16'hF800;
  localparam logic [15:0] SPC_LOW_POWER_STOP_INSTR = 16'h01C0;
  localparam logic [9:0] OP_TABLE = 10'h3E4;
  localparam logic [11:0] RC_SFC = 12'h000;
  localparam logic [11:0] RC_DFC = 12'h001;
  localparam logic [11:0] RC_VBR = 12'h801;
  localparam logic [1:0] CSEL_SFC = 2'h0;
  localparam logic [1:0] CSEL_DFC = 2'h1;
  localparam logic [1:0] CSEL_VBR = 2'h2;
  localparam logic [3:0] CLS_GENERIC = 4'h0;
  localparam logic [3:0] CLS_NOP = 4'h1;
  localparam logic [3:0] CLS_IMM = 4'h2;
  localparam logic [3:0] CLS_MOVE = 4'h3;
  localparam logic [3:0] CLS_MOVEC = 4'h4;
  localparam logic [3:0] CLS_MULL = 4'h5;
  localparam logic [3:0] CLS_DIVL = 4'h6;
  localparam logic [3:0] CLS_BRANCH = 4'h7;
  localparam logic [3:0] CLS_MOVEQ = 4'h8;
  localparam logic [3:0] CLS_LOW_POWER_STOP_INSTR = 4'h9;
  localparam logic [3:0] CLS_TABLE = 4'hA;
  localparam logic [3:0] CLS_UNIMPL = 4'hB;
  localparam logic [3:0] CLS_ILLEGAL = 4'hC;
  localparam logic [1:0] LOC_NONE = 2'h0;
  localparam logic [1:0] LOC_REG = 2'h1;
  localparam logic [1:0] LOC_EA = 2'h2;
  localparam logic [1:0] LOC_IMPL = 2'h3;
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_W = 2'h1;
  localparam logic [1:0] SZ_L = 2'h2;
  localparam logic [41:0] ROUND_HALF = 42'h00000000080;
  localparam logic [31:0] MASK_B = 32'h000000FF;
  localparam logic [31:0] MASK_W = 32'h0000FFFF;
  localparam logic [31:0] MASK_WU = 32'h00FFFFFF;
  localparam logic [31:0] MASK_L = 32'hFFFFFFFF;
  typedef enum logic [3:0] {
    ST_OP = 4'h1,
    ST_EXT = 4'h2,
    ST_DISP = 4'h4,
    ST_STOP = 4'h8
  } iwd_state_type;
endpackage
`default_nettype wire

// ===== logic/iwd_decoder.sv
// Instruction word decoder with register file, status register and Wishbone slave.
`timescale 1ns/10ps
`default_nettype none
module iwd_decoder
  import iwd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic iw_valid,
  input wire logic [15:0] iw_data,
  output logic iw_ready,
  output logic disp_valid,
  input wire logic disp_ready,
  output logic [3:0] disp_class,
  output logic [2:0] disp_len,
  output logic [6:0][15:0] disp_words,
  output logic [1:0] disp_size,
  output logic [1:0] src_loc,
  output logic [2:0] src_reg,
  output logic src_bank,
  output logic [1:0] dst_loc,
  output logic [2:0] dst_reg,
  output logic dst_bank,
  output logic [2:0] aux_reg_a,
  output logic [2:0] aux_reg_b,
  output logic [1:0] ctl_sel,
  output logic trap_unimpl,
  output logic trap_illegal,
  input wire logic rf_we,
  input wire logic rf_bank,
  input wire logic [2:0] rf_num,
  input wire logic [31:0] rf_wdata,
  input wire logic rf_we2,
  input wire logic [2:0] rf_num2,
  input wire logic [31:0] rf_wdata2,
  input wire logic rf_rd_bank,
  input wire logic [2:0] rf_rd_num,
  output logic [31:0] rf_rdata,
  input wire logic ctl_we,
  input wire logic [31:0] ctl_wdata,
  output logic [31:0] ctl_rdata,
  input wire logic ccr_we,
  input wire logic [4:0] ccr_wdata,
  output logic [15:0] status_reg,
  input wire logic [2:0] irq_level,
  output logic stop_active,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import iwd_pkg::*;

  typedef struct packed {
    logic [3:0] cls;
    logic [2:0] len;
    logic [1:0] size, src_loc, dst_loc;
    logic [2:0] src_reg, dst_reg;
    logic src_bank, dst_bank;
  } iwd_dec_type;

  typedef struct packed {
    iwd_state_type st;
    logic [6:0][15:0] words;
    logic [2:0] cnt;
    iwd_dec_type d;
    logic [2:0] aux_a, aux_b;
    logic [1:0] csel;
    logic tr_unimpl, tr_illegal;
    logic [7:0][31:0] dreg;
    logic [6:0][31:0] areg;
    logic [31:0] supervisor_stack_pointer, user_stack_pointer, vector_base_reg;
    logic [15:0] sr;
    logic [2:0] source_function_code_reg, dfc;
    logic dec_en, sticky_unimpl, sticky_illegal, ack;
    logic [31:0] wb_rd, rf_rd, ctl_rd;
  } iwd_regs_type;

  iwd_regs_type r_ff;
  iwd_regs_type nxt_r;

  // Returns {bad, count} of extension words for one effective address.
  function automatic logic [3:0] ea_ext(input logic [2:0] mode, input logic [2:0] rg,
                                        input logic lng);
    logic [3:0] e;
    e = 4'h0;
    if (mode == 3'h5 || mode == 3'h6)
      e = 4'h1;
    else if (mode == 3'h7)
    begin
      unique case (rg)
        3'h0, 3'h2, 3'h3: e = 4'h1;
        3'h1: e = 4'h2;
        3'h4: e = lng ? 4'h2 : 4'h1;
        default: e = 4'h8;
      endcase
    end
    return e;
  endfunction

  function automatic logic [31:0] sext_sz(input logic [31:0] v, input logic [1:0] sz);
    logic [31:0] o;
    o = v;
    if (sz == SZ_B)
      o = {{24{v[7]}}, v[7:0]};
    else if (sz == SZ_W)
      o = {{16{v[15]}}, v[15:0]};
    return o;
  endfunction

  function automatic iwd_dec_type decode_op(input logic [15:0] op);
    iwd_dec_type d;
    logic [3:0] se, de, tot;
    logic [1:0] spec;
    logic lng;
    d = '0;
    se = 4'h0;
    de = 4'h0;
    spec = 2'h0;
    lng = (op[7:6] == SZ_L);
    d.size = op[7:6];
    d.cls = CLS_GENERIC;
    d.src_loc = LOC_EA;
    d.src_reg = op[2:0];
    d.dst_reg = op[11:9];
    d.src_bank = (op[5:3] == 3'h1);
    d.dst_loc = LOC_REG;
    unique case (op[15:12])
      4'h0:
      begin
        d.dst_loc = LOC_EA;
        d.dst_reg = op[2:0];
        d.dst_bank = (op[5:3] == 3'h1);
        if (!op[8])
        begin
          d.cls = (op[7:6] == 2'h3) ? CLS_ILLEGAL : CLS_IMM;
          se = lng ? 4'h2 : 4'h1;
          de = ea_ext(op[5:3], op[2:0], lng);
        end
        else
        begin
          d.src_loc = LOC_REG;
          d.src_reg = op[11:9];
          d.src_bank = 1'b0;
          de = ea_ext(op[5:3], op[2:0], 1'b0);
        end
      end
      4'h1, 4'h2, 4'h3:
      begin
        d.cls = (op[8:6] == 3'h7 && op[11:9] > 3'h1) ? CLS_ILLEGAL : CLS_MOVE;
        lng = (op[13:12] == 2'h2);
        d.size = (op[13:12] == 2'h1) ? SZ_B : (lng ? SZ_L : SZ_W);
        d.dst_loc = LOC_EA;
        d.dst_bank = (op[8:6] == 3'h1);
        se = ea_ext(op[5:3], op[2:0], lng);
        de = ea_ext(op[8:6], op[11:9], lng);
      end
      4'h4:
      begin
        d.dst_loc = LOC_NONE;
        if (op == OP_NOP)
        begin
          d.cls = CLS_NOP;
          d.src_loc = LOC_NONE;
        end
        else if (op[15:1] == OP_MOVEC[15:1])
        begin
          d.cls = CLS_MOVEC;
          spec = 2'h1;
          d.src_loc = LOC_IMPL;
          d.dst_loc = LOC_IMPL;
        end
        else if (op[15:7] == OP_MULDIV)
        begin
          d.cls = op[6] ? CLS_DIVL : CLS_MULL;
          d.size = SZ_L;
          spec = 2'h1;
          d.dst_loc = LOC_IMPL;
          se = ea_ext(op[5:3], op[2:0], 1'b1);
        end
        else
          se = ea_ext(op[5:3], op[2:0], lng);
      end
      4'h5:
      begin
        d.src_loc = LOC_NONE;
        d.dst_loc = LOC_EA;
        d.dst_reg = op[2:0];
        d.dst_bank = (op[5:3] == 3'h1);
        de = ea_ext(op[5:3], op[2:0], lng);
      end
      4'h6:
      begin
        d.cls = CLS_BRANCH;
        d.src_loc = LOC_NONE;
        d.dst_loc = LOC_IMPL;
        se = (op[7:0] == 8'h00) ? 4'h1 : ((op[7:0] == 8'hFF) ? 4'h2 : 4'h0);
      end
      4'h7:
      begin
        d.cls = op[8] ? CLS_ILLEGAL : CLS_MOVEQ;
        d.src_loc = LOC_NONE;
        d.size = SZ_L;
      end
      4'h8, 4'h9, 4'hB, 4'hC, 4'hD:
      begin
        if (op[7:6] == 2'h3)
        begin
          d.dst_bank = 1'b1;
          d.size = op[8] ? SZ_L : SZ_W;
          lng = op[8];
        end
        se = ea_ext(op[5:3], op[2:0], lng);
      end
      4'hA: d.cls = CLS_UNIMPL;
      4'hE:
      begin
        d.src_loc = op[5] ? LOC_REG : LOC_NONE;
        d.src_reg = op[11:9];
        d.src_bank = 1'b0;
        d.dst_reg = op[2:0];
        if (op[7:6] == 2'h3)
        begin
          d.src_loc = LOC_NONE;
          d.dst_loc = LOC_EA;
          d.dst_bank = (op[5:3] == 3'h1);
          de = ea_ext(op[5:3], op[2:0], 1'b0);
        end
      end
      4'hF:
      begin
        d.src_loc = LOC_IMPL;
        d.dst_loc = LOC_IMPL;
        if (op == OP_LOW_POWER_STOP_INSTR)
        begin
          d.cls = CLS_LOW_POWER_STOP_INSTR;
          spec = 2'h2;
        end
        else if (op[15:6] == OP_TABLE)
        begin
          d.cls = CLS_TABLE;
          spec = 2'h1;
        end
        else
          d.cls = CLS_UNIMPL;
      end
    endcase
    // Specifiers, then source, then destination words
    tot = 4'h1 + {2'h0, spec} + {1'b0, se[2:0]} + {1'b0, de[2:0]};
    if (se[3] || de[3] || tot > MAX_WORDS)
      d.cls = CLS_ILLEGAL;
    // Length fixed from the operation word
    d.len = (d.cls == CLS_ILLEGAL || d.cls == CLS_UNIMPL) ? 3'h1 : tot[2:0];
    return d;
  endfunction

  always_comb
  begin
    iwd_dec_type nd;
    logic take;
    logic [2:0] dx;
    logic [31:0] ym, yn, res, msk, old;
    logic [41:0] diff, prod, interp, rnd;
    nxt_r = r_ff;
    nd = decode_op(iw_data);
    take = wb_cyc_i && wb_stb_i && !r_ff.ack;
    dx = 3'h0;
    ym = 32'h0;
    yn = 32'h0;
    res = 32'h0;
    msk = 32'h0;
    old = 32'h0;
    diff = 42'h0;
    prod = 42'h0;
    interp = 42'h0;
    rnd = 42'h0;
    nxt_r.ack = take;
    if (take)
    begin
      unique case (wb_adr_i)
        ADR_CTRL: nxt_r.wb_rd = {31'h0, r_ff.dec_en};
        ADR_STATUS: nxt_r.wb_rd = {28'h0, r_ff.sticky_illegal, r_ff.sticky_unimpl,
                                   r_ff.st != ST_OP, r_ff.st == ST_STOP};
        ADR_SR: nxt_r.wb_rd = {16'h0, r_ff.sr};
        ADR_VBR: nxt_r.wb_rd = r_ff.vector_base_reg;
        ADR_SFC: nxt_r.wb_rd = {29'h0, r_ff.source_function_code_reg};
        ADR_DFC: nxt_r.wb_rd = {29'h0, r_ff.dfc};
        default: nxt_r.wb_rd = 32'h0;
      endcase
    end
    if (take && wb_we_i)
    begin
      if (wb_adr_i == ADR_CTRL && wb_sel_i[0])
        nxt_r.dec_en = wb_dat_i[0];
      if (wb_adr_i == ADR_STATUS && wb_sel_i[0])
      begin
        nxt_r.sticky_unimpl = r_ff.sticky_unimpl & ~wb_dat_i[2];
        nxt_r.sticky_illegal = r_ff.sticky_illegal & ~wb_dat_i[3];
      end
      if (wb_adr_i == ADR_SR)
      begin
        if (wb_sel_i[0])
          nxt_r.sr[7:0] = wb_dat_i[7:0] & SR_WMASK[7:0];
        if (wb_sel_i[1])
          nxt_r.sr[15:8] = wb_dat_i[15:8] & SR_WMASK[15:8];
      end
      for (int b = 0; b < 4; b++)
        if (wb_adr_i == ADR_VBR && wb_sel_i[b])
          nxt_r.vector_base_reg[b*8 +: 8] = wb_dat_i[b*8 +: 8];
      if (wb_adr_i == ADR_SFC && wb_sel_i[0])
        nxt_r.source_function_code_reg = wb_dat_i[2:0];
      if (wb_adr_i == ADR_DFC && wb_sel_i[0])
        nxt_r.dfc = wb_dat_i[2:0];
    end
    // Two banks of eight; seven is the active stack pointer
    if (rf_we && rf_bank && rf_num == 3'h7 && r_ff.sr[SR_S])
      nxt_r.supervisor_stack_pointer = rf_wdata;
    else if (rf_we && rf_bank && rf_num == 3'h7)
      nxt_r.user_stack_pointer = rf_wdata;
    else if (rf_we && rf_bank)
      nxt_r.areg[rf_num] = rf_wdata;
    else if (rf_we)
      nxt_r.dreg[rf_num] = rf_wdata;
    // Second data port for high and low product halves
    if (rf_we2)
      nxt_r.dreg[rf_num2] = rf_wdata2;
    if (rf_rd_bank && rf_rd_num == 3'h7)
      nxt_r.rf_rd = r_ff.sr[SR_S] ? r_ff.supervisor_stack_pointer : r_ff.user_stack_pointer;
    else if (rf_rd_bank)
      nxt_r.rf_rd = r_ff.areg[rf_rd_num];
    else
      nxt_r.rf_rd = r_ff.dreg[rf_rd_num];
    if (ctl_we && r_ff.csel == CSEL_SFC)
      nxt_r.source_function_code_reg = ctl_wdata[2:0];
    if (ctl_we && r_ff.csel == CSEL_DFC)
      nxt_r.dfc = ctl_wdata[2:0];
    if (ctl_we && r_ff.csel == CSEL_VBR)
      nxt_r.vector_base_reg = ctl_wdata;
    nxt_r.ctl_rd = (r_ff.csel == CSEL_VBR) ? r_ff.vector_base_reg :
                   {29'h0, (r_ff.csel == CSEL_SFC) ? r_ff.source_function_code_reg : r_ff.dfc};
    // Flags in the status low byte; five of them
    if (ccr_we)
      nxt_r.sr[4:0] = ccr_wdata;
    unique case (r_ff.st)
      ST_OP:
        if (iw_valid && iw_ready)
        begin
          nxt_r.words = '0;
          nxt_r.words[0] = iw_data;
          nxt_r.cnt = 3'h1;
          nxt_r.d = nd;
          nxt_r.aux_a = 3'h0;
          nxt_r.aux_b = 3'h0;
          nxt_r.tr_unimpl = (nd.cls == CLS_UNIMPL);
          nxt_r.tr_illegal = (nd.cls == CLS_ILLEGAL);
          nxt_r.st = (nd.len == 3'h1) ? ST_DISP : ST_EXT;
        end
      ST_EXT:
        if (iw_valid && iw_ready)
        begin
          nxt_r.words[r_ff.cnt] = iw_data;
          nxt_r.cnt = 3'(r_ff.cnt + 3'h1);
          if (nxt_r.cnt == r_ff.d.len)
            nxt_r.st = ST_DISP;
        end
      ST_DISP:
        if (disp_ready)
          nxt_r.st = (r_ff.d.cls == CLS_LOW_POWER_STOP_INSTR && !r_ff.tr_illegal) ? ST_STOP : ST_OP;
      ST_STOP:
        // Wake at or above the mask
        if (irq_level != 3'h0 && irq_level >= r_ff.sr[10:8])
          nxt_r.st = ST_OP;
    endcase
    if (r_ff.st != ST_DISP && nxt_r.st == ST_DISP)
    begin
      unique case (nxt_r.d.cls)
        CLS_MOVEC:
        begin
          nxt_r.aux_a = nxt_r.words[1][14:12];
          nxt_r.d.src_loc = nxt_r.words[0][0] ? LOC_REG : LOC_IMPL;
          nxt_r.d.dst_loc = nxt_r.words[0][0] ? LOC_IMPL : LOC_REG;
          nxt_r.d.src_reg = nxt_r.words[1][14:12];
          nxt_r.d.dst_reg = nxt_r.words[1][14:12];
          nxt_r.d.src_bank = nxt_r.words[1][15];
          nxt_r.d.dst_bank = nxt_r.words[1][15];
          if (nxt_r.words[1][11:0] == RC_SFC)
            nxt_r.csel = CSEL_SFC;
          else if (nxt_r.words[1][11:0] == RC_DFC)
            nxt_r.csel = CSEL_DFC;
          else if (nxt_r.words[1][11:0] == RC_VBR)
            nxt_r.csel = CSEL_VBR;
          else
            nxt_r.tr_illegal = 1'b1;
        end
        // Low and high; quotient and remainder
        CLS_MULL, CLS_DIVL:
        begin
          nxt_r.aux_a = nxt_r.words[1][14:12];
          nxt_r.aux_b = nxt_r.words[1][2:0];
        end
        CLS_LOW_POWER_STOP_INSTR:
          if (nxt_r.words[1] != SPC_LOW_POWER_STOP_INSTR || !r_ff.sr[SR_S])
            nxt_r.tr_illegal = 1'b1;
          else
            nxt_r.sr = nxt_r.words[2] & SR_WMASK;
        CLS_TABLE:
        begin
          dx = nxt_r.words[1][14:12];
          nxt_r.aux_a = nxt_r.words[0][2:0];
          nxt_r.aux_b = nxt_r.words[0][5:3];
          nxt_r.d.dst_reg = dx;
          nxt_r.d.size = nxt_r.words[1][7:6];
          if (nxt_r.d.size == 2'h3 || (nxt_r.words[1][11] && nxt_r.d.size == SZ_L))
            nxt_r.tr_illegal = 1'b1;
          else
          begin
            ym = sext_sz(nxt_r.dreg[nxt_r.aux_a], nxt_r.d.size);
            yn = sext_sz(nxt_r.dreg[nxt_r.aux_b], nxt_r.d.size);
            old = nxt_r.dreg[dx];
            diff = {{10{yn[31]}}, yn} - {{10{ym[31]}}, ym};
            prod = 42'($signed(diff) * $signed({1'b0, old[7:0]}));
            interp = {{2{ym[31]}}, ym, 8'h00} + prod;
            rnd = interp + ROUND_HALF;
            res = nxt_r.words[1][11] ? interp[31:0] : rnd[39:8];
            if (nxt_r.d.size == SZ_B)
              msk = nxt_r.words[1][11] ? MASK_W : MASK_B;
            else if (nxt_r.d.size == SZ_W)
              msk = nxt_r.words[1][11] ? MASK_WU : MASK_W;
            else
              msk = MASK_L;
            nxt_r.dreg[dx] = (old & ~msk) | (res & msk);
          end
        end
        default:
        begin
        end
      endcase
      // Folded in last so traps found in the specifier words stick as well.
      nxt_r.sticky_unimpl = nxt_r.sticky_unimpl | nxt_r.tr_unimpl;
      nxt_r.sticky_illegal = nxt_r.sticky_illegal | nxt_r.tr_illegal;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_ff <= '0;
      r_ff.st <= ST_OP;
      r_ff.sr <= SR_RESET;
      r_ff.dec_en <= 1'b1;
    end
    else if (ce)
      r_ff <= nxt_r;
  end

  assign iw_ready = ce && r_ff.dec_en && (r_ff.st == ST_OP || r_ff.st == ST_EXT);
  assign disp_valid = (r_ff.st == ST_DISP);
  assign disp_class = r_ff.d.cls;
  assign disp_len = r_ff.d.len;
  assign disp_words = r_ff.words;
  assign disp_size = r_ff.d.size;
  assign src_loc = r_ff.d.src_loc;
  assign src_reg = r_ff.d.src_reg;
  assign src_bank = r_ff.d.src_bank;
  assign dst_loc = r_ff.d.dst_loc;
  assign dst_reg = r_ff.d.dst_reg;
  assign dst_bank = r_ff.d.dst_bank;
  assign aux_reg_a = r_ff.aux_a;
  assign aux_reg_b = r_ff.aux_b;
  assign ctl_sel = r_ff.csel;
  assign trap_unimpl = r_ff.tr_unimpl;
  assign trap_illegal = r_ff.tr_illegal;
  assign rf_rdata = r_ff.rf_rd;
  assign ctl_rdata = r_ff.ctl_rd;
  assign status_reg = r_ff.sr;
  assign stop_active = (r_ff.st == ST_STOP);
  assign wb_dat_o = r_ff.wb_rd;
  assign wb_ack_o = r_ff.ack;
endmodule // iwd_decoder
`default_nettype wire

// ===== sim/iwd_decoder_props.sv
// Checker on the decoder ports: dispatch, traps, flags and standby.
`timescale 1ns/10ps
`default_nettype none
module iwd_decoder_props (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic iw_ready,
  input wire logic disp_valid,
  input wire logic disp_ready,
  input wire logic [3:0] disp_class,
  input wire logic [2:0] disp_len,
  input wire logic [6:0][15:0] disp_words,
  input wire logic trap_unimpl,
  input wire logic trap_illegal,
  input wire logic ccr_we,
  input wire logic [4:0] ccr_wdata,
  input wire logic [15:0] status_reg,
  input wire logic [2:0] irq_level,
  input wire logic stop_active
);
  import iwd_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  len_nonzero_a: assert property (disp_valid |-> disp_len != 3'h0)
    else $error("zero length dispatched");
  no_intake_a: assert property (disp_valid |-> !iw_ready)
    else $error("intake open while dispatching");
  hold_words_a:
    assert property (disp_valid && !disp_ready |=> disp_valid && $stable(disp_words))
    else $error("dispatch changed before taken");
  unimpl_trap_a:
    assert property (disp_valid && trap_unimpl |-> disp_class == CLS_UNIMPL && disp_len == 3'h1)
    else $error("unimplemented trap malformed");
  illegal_class_a:
    assert property (disp_valid && disp_class == CLS_ILLEGAL
      |-> trap_illegal && disp_len == 3'h1)
    else $error("illegal class without trap");
  ccr_write_a: assert property (ccr_we && ce |=> status_reg[4:0] == $past(ccr_wdata))
    else $error("flag write lost");
  ccr_width_a: assert property (status_reg[7:5] == 3'h0)
    else $error("flag byte has extra bits");
  stop_entry_a:
    assert property (disp_valid && disp_ready && ce && disp_class == CLS_LOW_POWER_STOP_INSTR && !trap_illegal
      |-> ##[1:2] stop_active)
    else $error("standby not entered");
  stop_hold_a:
    assert property (stop_active && ce && (irq_level == 3'h0 || irq_level < status_reg[10:8])
      |=> stop_active)
    else $error("standby left early");
  stop_wake_a:
    assert property (stop_active && ce && irq_level != 3'h0 && irq_level >= status_reg[10:8]
      |-> ##[1:2] !stop_active)
    else $error("standby not left");
  stop_block_a: assert property (stop_active |-> !iw_ready)
    else $error("intake open in standby");
endmodule // iwd_decoder_props
`default_nettype wire

// ===== sim/iwd_feed.sv
// Prefetch queue model that hands instruction words to the decoder.
`timescale 1ns/10ps
`default_nettype none
module iwd_feed (
  input wire logic ref_clk,
  input wire logic iw_ready,
  output logic iw_valid,
  output logic [15:0] iw_data
);
  logic [15:0] q [$];
  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask
  initial
  begin
    iw_valid = 1'b0;
    iw_data = 16'h0000;
  end
  always @(posedge ref_clk)
  begin
    if (iw_valid && iw_ready)
      void'(q.pop_front());
    iw_valid <= q.size() != 0;
    // Idle lines show the inverse so a stale word cannot pass for a fresh one.
    iw_data <= q.size() != 0 ? q[0] : ~iw_data;
  end
endmodule // iwd_feed
`default_nettype wire

// ===== sim/instruction_word_decoder_test.sv
// Self-checking bench for the instruction word decoder.
`timescale 1ns/10ps
`default_nettype none
module instruction_word_decoder_test;
  import iwd_pkg::*;
  logic ref_clk, rst_b, ce, iw_valid, iw_ready, disp_valid, disp_ready, src_bank, dst_bank;
  logic trap_unimpl, trap_illegal, rf_we, rf_bank, rf_we2, rf_rd_bank, ctl_we, ccr_we;
  logic stop_active, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [15:0] iw_data, status_reg;
  logic [6:0][15:0] disp_words;
  logic [3:0] disp_class, wb_sel_i;
  logic [2:0] disp_len, src_reg, dst_reg, aux_reg_a, aux_reg_b, rf_num, rf_num2, rf_rd_num;
  logic [2:0] irq_level;
  logic [1:0] disp_size, src_loc, dst_loc, ctl_sel;
  logic [31:0] rf_wdata, rf_wdata2, rf_rdata, ctl_wdata, ctl_rdata, wb_dat_i, wb_dat_o, r;
  logic [7:0] wb_adr_i;
  logic [4:0] ccr_wdata;
  int n_mismatch, comparisons, cyc;
  iwd_decoder i_iwd_decoder (.*);
  iwd_feed i_iwd_feed (.ref_clk(ref_clk), .iw_ready(iw_ready), .iw_valid(iw_valid),
    .iw_data(iw_data));
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, 4'hF};
    do
      @(posedge ref_clk);
    while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic issue(input int n, input logic [47:0] w);
    for (int i = 0; i < n; i++)
      i_iwd_feed.push(w[47-16*i -: 16]);
    for (int k = 0; k < 20 && disp_valid !== 1'b1; k++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk("valid", disp_valid, 1'b1);
    chk("len", disp_len, n);
    chk("op", disp_words[0], w[47:32]);
    chk("ext", disp_words[n-1], w[63-16*n -: 16]);
  endtask
  task automatic retire;
    @(posedge ref_clk);
    disp_ready <= 1'b1;
    @(posedge ref_clk);
    disp_ready <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic b, input logic [2:0] n, input logic [31:0] e);
    @(posedge ref_clk);
    {rf_rd_bank, rf_rd_num} <= {b, n};
    @(posedge ref_clk);
    #1;
    chk("rf", rf_rdata, e);
  endtask
  task automatic t_basic;
    logic [11:0] rc [3] = '{RC_SFC, RC_DFC, RC_VBR};
    logic [1:0] cs [3] = '{CSEL_SFC, CSEL_DFC, CSEL_VBR};
    logic [7:0] ad [3] = '{ADR_SFC, ADR_DFC, ADR_VBR};
    issue(1, {OP_NOP, 32'h0});
    chk("nop", disp_class, CLS_NOP);
    retire;
    for (int i = 0; i < 3; i++)
    begin
      issue(2, {OP_MOVEC, 4'h2, rc[i], 16'h0});
      chk("csel", ctl_sel, cs[i]);
      chk("impl", src_loc, LOC_IMPL);
      @(posedge ref_clk);
      {ctl_we, ctl_wdata} <= {1'b1, 32'h5};
      @(posedge ref_clk);
      ctl_we <= 1'b0;
      retire;
      chk("crd", ctl_rdata, 32'h5);
      wb(1'b0, ad[i], 32'h0);
      chk("ctl", r, 32'h5);
    end
    $display("test basic done");
  endtask
  task automatic t_unimpl;
    issue(1, {16'hA000, 32'h0});
    chk("trap", trap_unimpl, 1'b1);
    retire;
    issue(1, {16'h7100, 32'h0});
    chk("icls", disp_class, CLS_ILLEGAL);
    chk("itrap", trap_illegal, 1'b1);
    retire;
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("sticky", r[2], 1'b1);
    chk("isticky", r[3], 1'b1);
    wb(1'b1, ADR_STATUS, 32'hC);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("clear", r[3:2], 2'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", r, 32'h0);
    $display("test unimpl done");
  endtask
  task automatic t_muldiv;
    issue(2, {16'h4C03, 16'h3405, 16'h0});
    chk("mcls", disp_class, CLS_MULL);
    chk("lo", aux_reg_a, 3'h3);
    chk("hi", aux_reg_b, 3'h5);
    chk("src", src_reg, 3'h3);
    retire;
    issue(2, {16'h4C40, 16'h2406, 16'h0});
    chk("dcls", disp_class, CLS_DIVL);
    chk("quo", aux_reg_a, 3'h2);
    chk("rem", aux_reg_b, 3'h6);
    retire;
    $display("test muldiv done");
  endtask
  task automatic t_regs;
    @(posedge ref_clk);
    {rf_we, rf_bank, rf_num, rf_wdata} <= {2'h3, 3'h7, 32'h5555AAAA};
    {rf_we2, rf_num2, rf_wdata2} <= {1'b1, 3'h7, 32'h00000D07};
    @(posedge ref_clk);
    {rf_we, rf_we2} <= 2'h0;
    wb(1'b1, ADR_SR, 32'h0);
    @(posedge ref_clk);
    {rf_we, rf_wdata} <= {1'b1, 32'h00001234};
    @(posedge ref_clk);
    rf_we <= 1'b0;
    rd(1'b1, 3'h7, 32'h00001234);
    rd(1'b0, 3'h7, 32'h00000D07);
    wb(1'b1, ADR_SR, 32'h2700);
    rd(1'b1, 3'h7, 32'h5555AAAA);
    $display("test regs done");
  endtask
  task automatic t_stop;
    issue(3, {OP_LOW_POWER_STOP_INSTR, SPC_LOW_POWER_STOP_INSTR, 16'h2300});
    chk("scls", disp_class, CLS_LOW_POWER_STOP_INSTR);
    chk("spec", disp_words[1], SPC_LOW_POWER_STOP_INSTR);
    retire;
    repeat (2) @(posedge ref_clk);
    irq_level <= 3'h2;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("stop", stop_active, 1'b1);
    chk("rdy", iw_ready, 1'b0);
    @(posedge ref_clk);
    irq_level <= 3'h3;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("wake", stop_active, 1'b0);
    @(posedge ref_clk);
    {irq_level, ccr_we, ccr_wdata} <= {3'h0, 1'b1, 5'h15};
    @(posedge ref_clk);
    ccr_we <= 1'b0;
    wb(1'b0, ADR_SR, 32'h0);
    chk("sr", r, 32'h2315);
    $display("test stop done");
  endtask
  task automatic t_move;
    issue(3, {16'h377C, 16'h1234, 16'h0008});
    chk("mv", disp_class, CLS_MOVE);
    chk("imm", disp_words[1], 16'h1234);
    chk("dext", disp_words[2], 16'h0008);
    chk("sloc", src_loc, LOC_EA);
    chk("dreg", dst_reg, 3'h3);
    retire;
    issue(1, {16'h300D, 32'h0});
    chk("sbank", src_bank, 1'b1);
    chk("sreg", src_reg, 3'h5);
    chk("dloc", dst_loc, LOC_EA);
    chk("dbank", dst_bank, 1'b0);
    retire;
    $display("test move done");
  endtask
  task automatic t_table;
    @(posedge ref_clk);
    {rf_we, rf_bank, rf_num, rf_wdata} <= {2'h2, 3'h2, 32'h80};
    {rf_we2, rf_num2, rf_wdata2} <= {1'b1, 3'h0, 32'h10};
    @(posedge ref_clk);
    {rf_we, rf_num, rf_wdata, rf_we2} <= {1'b1, 3'h1, 32'h30, 1'b0};
    @(posedge ref_clk);
    rf_we <= 1'b0;
    issue(2, {16'hF908, 16'h2000, 16'h0});
    chk("tcls", disp_class, CLS_TABLE);
    chk("ym", aux_reg_a, 3'h0);
    chk("yn", aux_reg_b, 3'h1);
    chk("tsz", disp_size, SZ_B);
    retire;
    rd(1'b0, 3'h2, 32'h20);
    issue(2, {16'hF908, 16'h2800, 16'h0});
    retire;
    rd(1'b0, 3'h2, 32'h1400);
    issue(2, {16'hF908, 16'h2080, 16'h0});
    retire;
    rd(1'b0, 3'h2, 32'h10);
    issue(2, {16'hF908, 16'h2880, 16'h0});
    chk("tlong", trap_illegal, 1'b1);
    retire;
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("stick", r[3], 1'b1);
    $display("test table done");
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // The ceiling leaves ample room over the fewer than two hundred cycles the tests need.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      complete_run;
    end
  end
  initial
  begin
    {rst_b, ce} = 2'h1;
    {disp_ready, rf_we, rf_bank, rf_we2, rf_rd_bank, ctl_we, ccr_we, irq_level} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
    {rf_num, rf_num2, rf_rd_num, rf_wdata, rf_wdata2, ctl_wdata, ccr_wdata} = '0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_basic;
    t_unimpl;
    t_muldiv;
    t_move;
    t_regs;
    t_stop;
    t_table;
    complete_run;
  end
endmodule // instruction_word_decoder_test
bind iwd_decoder iwd_decoder_props i_iwd_decoder_props (.*);
`default_nettype wire
